// ### rtl/bringup_pkg.sv
package bringup_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OSCILLATOR_BIAS_VAL = 8'h4a;
    localparam int CLK_MHZ = 100;
    localparam int POLL_TIMEOUT_US = 1000;
    localparam int POLL_TIMEOUT_CYC = POLL_TIMEOUT_US * CLK_MHZ;
    localparam int INIT_TIME_US = 10;
    localparam int INIT_CYC = INIT_TIME_US * CLK_MHZ;
    localparam int TRIM_CYC = 64;
    localparam int LOCK_CYC = 32;
    localparam int CAL_CYC = 128;
    // host command registers, word aligned
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] A_PLLCFG = 8'h08;
    localparam logic [ADDR_W-1:0] A_LINKCFG = 8'h0c;
    localparam logic [ADDR_W-1:0] A_CALCFG = 8'h10;
    // ctrl bits
    localparam int C_START = 0;
    localparam int C_STRAP_PLL = 1;
    localparam int C_STRAP_SE = 2;
    localparam int C_PWRDN = 3;
    localparam int C_TRIM_AUTO = 4;
    localparam int C_AUX_EN = 5;
    localparam int C_OVERRANGE_ENABLE = 6;
    localparam int C_PINTRIG = 7;
    // status bits
    localparam int S_BUSY = 0;
    localparam int S_DONE = 1;
    localparam int S_ERR = 2;
    localparam int S_VALID = 3;
    localparam int S_CALDONE = 4;
    localparam int S_STEP = 8;
    // linkcfg: mode[3:0], k-1[11:4], syncsel[12]
    localparam int L_SYNCSEL = 12;
    localparam int MODE_W = 4;
    localparam int K_W = 8;
    // modes below this value use 8b/10b
    localparam logic [3:0] MODE_FIRST_66 = 4'h8;
    // device register set reached over the link
    typedef enum logic [3:0] {
        DR_SOFT_RESET, DR_PLL_RESET, DR_OSC_BIAS, DR_PLL_DIV, DR_TRIM_CAL, DR_TRIM_VAL,
        DR_LINK_EN, DR_CAL_EN, DR_MODE, DR_KM1, DR_SYNC_SEL, DR_CAL_CFG, DR_AUX_CTRL,
        DR_OVR, DR_CAL_TRIG, DR_STATUS
    } dev_reg_t;
    localparam int DST_INIT = 0;
    localparam int DST_TRIM = 1;
    localparam int DST_LOCK = 2;
    localparam int DST_FG = 3;
endpackage : bringup_pkg

// ### rtl/bringup_if.sv
`timescale 1ns/1ps
interface bringup_if;
    import bringup_pkg::*;
    logic pllStrap;
    logic refSelStrap;
    logic powerDownPin;
    logic wrEn;
    bringup_pkg::dev_reg_t regAddr;
    logic [15:0] wrData;
    logic [15:0] rdData;
    logic calTriggerPin;
    logic calStatusPin;
    logic syncReq;
    logic syncSePin;
    logic tmstpPin;
    logic linkUp;
    modport host (output pllStrap, refSelStrap, powerDownPin, wrEn, regAddr, wrData,
        calTriggerPin, syncSePin, tmstpPin, input rdData, calStatusPin, syncReq, linkUp);
    modport device (input pllStrap, refSelStrap, powerDownPin, wrEn, regAddr, wrData,
        calTriggerPin, syncSePin, tmstpPin, output rdData, calStatusPin, syncReq, linkUp);
endinterface : bringup_if

// ### rtl/converter_device.sv
`timescale 1ns/1ps
module converter_device (
    input wire logic clk,
    input wire logic sys_rst,
    bringup_if.device link,
    output logic linkRunning,
    output logic calRunning
);
    import bringup_pkg::*;
    logic [15:0] regs_r [16];
    logic [15:0] initCnt_r, trimCnt_r, lockCnt_r, calCnt_r;
    logic initDone_r, trimDone_r, lockDone_r, fgDone_r, calibration_status_pin_r;
    logic trigPrev_r, pinS1_r, pinS2_r, pinPrev_r;
    logic seS1_r, seS2_r, tmS1_r, tmS2_r;
    logic calGo, pllOn, syncIn;

    assign pllOn = link.pllStrap;
    // write port, cleared only by sys_rst
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 16; i++) regs_r[i] <= 16'h0000;
        end else if (link.wrEn) begin
            regs_r[link.regAddr] <= link.wrData;
        end
    end
    // init timer after soft reset [R5]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            initCnt_r <= 16'h0000;
            initDone_r <= 1'b0;
        end else if (link.wrEn && link.regAddr == DR_SOFT_RESET && link.wrData[0]) begin
            initCnt_r <= 16'(INIT_CYC);
            initDone_r <= 1'b0;
        end else if (initCnt_r > 16'h0001) begin
            initCnt_r <= initCnt_r - 16'h0001;
        end else if (initCnt_r == 16'h0001) begin
            initCnt_r <= 16'h0000;
            initDone_r <= 1'b1; // [R5]
        end
    end
    // pll release starts trim then lock [R8] [R16]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            trimCnt_r <= 16'h0000;
            lockCnt_r <= 16'h0000;
            trimDone_r <= 1'b0;
            lockDone_r <= 1'b0;
        end else if (!pllOn || regs_r[DR_PLL_RESET][0]) begin
            trimCnt_r <= 16'h0000;
            lockCnt_r <= 16'h0000;
            trimDone_r <= 1'b0;
            lockDone_r <= 1'b0;
        end else if (!trimDone_r) begin
            // manual trim skips calibration [R8]
            if (!regs_r[DR_TRIM_CAL][0] || trimCnt_r == 16'(TRIM_CYC)) trimDone_r <= 1'b1;
            else trimCnt_r <= trimCnt_r + 16'h0001;
        end else if (!lockDone_r) begin
            if (lockCnt_r == 16'(LOCK_CYC)) lockDone_r <= 1'b1; // [R16]
            else lockCnt_r <= lockCnt_r + 16'h0001;
        end
    end
    // trigger, sync and timestamp pin synchronisers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinS1_r <= 1'b0;
            pinS2_r <= 1'b0;
            pinPrev_r <= 1'b0;
            trigPrev_r <= 1'b0;
            seS1_r <= 1'b0;
            seS2_r <= 1'b0;
            tmS1_r <= 1'b0;
            tmS2_r <= 1'b0;
        end else begin
            pinS1_r <= link.calTriggerPin;
            pinS2_r <= pinS1_r;
            pinPrev_r <= pinS2_r;
            trigPrev_r <= regs_r[DR_CAL_TRIG][0];
            seS1_r <= link.syncSePin;
            seS2_r <= seS1_r;
            tmS1_r <= link.tmstpPin;
            tmS2_r <= tmS1_r;
        end
    end
    // rising edge of the selected trigger source [R18] [R19]
    assign calGo = regs_r[DR_CAL_EN][0] && (regs_r[DR_CAL_TRIG][1]
        ? (pinS2_r && !pinPrev_r) : (regs_r[DR_CAL_TRIG][0] && !trigPrev_r));
    // foreground calibration halts while disabled [R11] [R20]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            calCnt_r <= 16'h0000;
            fgDone_r <= 1'b0;
            calibration_status_pin_r <= 1'b0;
        end else if (!regs_r[DR_CAL_EN][0]) begin
            calCnt_r <= 16'h0000; // [R11]
        end else if (calGo) begin
            calCnt_r <= 16'(CAL_CYC);
            fgDone_r <= 1'b0;
            calibration_status_pin_r <= 1'b0;
        end else if (calCnt_r == 16'h0001) begin
            calCnt_r <= 16'h0000;
            fgDone_r <= 1'b1; // [R20]
            calibration_status_pin_r <= 1'b1; // [R20]
        end else if (calCnt_r != 16'h0000) begin
            calCnt_r <= calCnt_r - 16'h0001;
        end
    end
    // sync source select, ignored for linkUp in 64b/66b while syncReq follows it in every mode [R13] [R21]
    assign syncIn = regs_r[DR_SYNC_SEL][0] ? tmS2_r : seS2_r; // [R13]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.linkUp <= 1'b0;
            link.syncReq <= 1'b0;
            link.calStatusPin <= 1'b0;
            link.rdData <= 16'h0000;
            linkRunning <= 1'b0;
            calRunning <= 1'b0;
        end else begin
            linkRunning <= regs_r[DR_LINK_EN][0]; // [R10]
            calRunning <= regs_r[DR_CAL_EN][0];
            link.calStatusPin <= calibration_status_pin_r;
            if (!regs_r[DR_LINK_EN][0]) link.linkUp <= 1'b0; // [R10]
            else if (regs_r[DR_MODE][3:0] >= MODE_FIRST_66) link.linkUp <= 1'b1; // [R21]
            else link.linkUp <= syncIn; // [R21]
            link.syncReq <= syncIn;
            link.rdData <= (link.regAddr == DR_STATUS)
                ? {12'h000, fgDone_r, lockDone_r, trimDone_r, initDone_r}
                : regs_r[link.regAddr];
        end
    end
endmodule : converter_device

// ### rtl/bringup_host.sv
`timescale 1ns/1ps
module bringup_host (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bringup_pkg::ADDR_W-1:0] paddr,
    input wire logic [bringup_pkg::DATA_W-1:0] pwdata,
    output logic [bringup_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    bringup_if.host link
);
    import bringup_pkg::*;
    // Summary of operation
    // [R1] strap pll pin: high uses pll
    // [R2] single-ended reference only with pll enabled
    // [R3] keep power-down low while clocks needed
    // [R4] stable reference before software reset
    // [R5] reset, then poll startup flag
    // [R6] pll reset, bias 0x4a, dividers
    // [R7] auto trim, or manual trim value
    // [R8] release pll reset starts trim
    // [R9] no pll: skip pll steps
    // [R10] stop link before link settings
    // [R11] stop calibration before calibration settings
    // [R12] multiframe length written as k-1
    // [R13] sync source pin selection
    // [R14] calibration mode and offset choice
    // [R15] optional aux clock output setup
    // [R16] confirm trim done and lock
    // [R17] cal enable, overrange, then link enable
    // [R18] software trigger written zero then one
    // [R19] pin trigger low then high
    // [R20] completion drives status pin and bit
    // [R21] sync used only in 8b/10b
    // [R22] valid after link up and calibration
    // [R23] every poll has a timeout
    typedef enum {
        IDLE, RST, POLL_INIT, PLL_RST, BIAS, DIV, TRIM, TRIM_VAL, PLL_REL, LINK_OFF, CAL_OFF,
        MODE, KM1, SYNC, CALCFG, AUX, POLL_LOCK, CAL_ON, OVR, LINK_ON, TRIG0, TRIG1,
        PIN_LO, PIN_HI, POLL_CAL, DONE, ERR
    } step_t;
    step_t step_r;
    logic [DATA_W-1:0] ctrl_r, pllCfg_r, linkCfg_r, calCfg_r;
    logic [31:0] timer_r;
    logic wait_r, valid_r, cs1_r, cs2_r, lu1_r, lu2_r;
    logic startReq;
    // straps must see the control word written together with start, not the stale one
    logic [DATA_W-1:0] ctrlNow;
    logic [15:0] st;

    assign st = link.rdData;
    assign ctrlNow = (psel && penable && pwrite && paddr == A_CTRL) ? pwdata : ctrl_r;
    assign startReq = psel && penable && pwrite && paddr == A_CTRL && pwdata[C_START];
    // apb slave, zero wait states
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= '0;
            pllCfg_r <= '0;
            linkCfg_r <= '0;
            calCfg_r <= '0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= !(paddr inside {A_CTRL, A_STATUS, A_PLLCFG, A_LINKCFG, A_CALCFG});
                unique case (paddr)
                    A_CTRL: prdata <= ctrl_r;
                    A_STATUS: prdata <= {16'h0000, 8'(step_r), 3'h0, cs2_r,
                        valid_r, step_r == ERR, step_r == DONE, step_r != IDLE};
                    A_PLLCFG: prdata <= pllCfg_r;
                    A_LINKCFG: prdata <= linkCfg_r;
                    A_CALCFG: prdata <= calCfg_r;
                    default: prdata <= '0;
                endcase
            end
            if (psel && penable && pwrite) begin
                unique case (paddr)
                    A_CTRL: ctrl_r <= pwdata;
                    A_PLLCFG: pllCfg_r <= pwdata;
                    A_LINKCFG: linkCfg_r <= pwdata;
                    A_CALCFG: calCfg_r <= pwdata;
                    default: ;
                endcase
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs1_r <= 1'b0;
            cs2_r <= 1'b0;
            lu1_r <= 1'b0;
            lu2_r <= 1'b0;
        end else begin
            cs1_r <= link.calStatusPin;
            cs2_r <= cs1_r;
            lu1_r <= link.linkUp;
            lu2_r <= lu1_r;
        end
    end
    // straps and power-down follow control only in IDLE, never re-entered after start; power-down is C_PWRDN held low while aux is enabled [R1] [R2] [R3]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.pllStrap <= 1'b0;
            link.refSelStrap <= 1'b0;
            link.powerDownPin <= 1'b0;
            link.syncSePin <= 1'b0;
            link.tmstpPin <= 1'b0;
        end else if (step_r == IDLE) begin
            link.pllStrap <= ctrlNow[C_STRAP_PLL]; // [R1]
            link.refSelStrap <= ctrlNow[C_STRAP_SE] && ctrlNow[C_STRAP_PLL]; // [R2]
            link.powerDownPin <= ctrlNow[C_PWRDN] && !ctrlNow[C_AUX_EN]; // [R3]
            link.syncSePin <= linkCfg_r[L_SYNCSEL + 1];
            link.tmstpPin <= linkCfg_r[L_SYNCSEL + 2];
        end
    end
    // sequencer: at most one device write per step, polls bounded by timer [R23]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_r <= IDLE;
            timer_r <= '0;
            wait_r <= 1'b0;
            valid_r <= 1'b0;
            link.wrEn <= 1'b0;
            link.regAddr <= DR_STATUS;
            link.wrData <= 16'h0000;
            link.calTriggerPin <= 1'b0;
        end else begin
            link.wrEn <= 1'b0;
            link.regAddr <= DR_STATUS;
            timer_r <= timer_r + 32'h1;
            // poll timeout [R23]
            if (timer_r >= 32'(POLL_TIMEOUT_CYC) &&
                step_r inside {POLL_INIT, POLL_LOCK, POLL_CAL}) step_r <= ERR;
            else unique case (step_r)
                IDLE: if (startReq) begin
                    step_r <= RST; // [R4]
                    valid_r <= 1'b0;
                end
                RST: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_SOFT_RESET;
                    link.wrData <= 16'h0001;
                    timer_r <= '0;
                    step_r <= POLL_INIT;
                end
                POLL_INIT: if (st[DST_INIT] && timer_r > 32'h2) // [R5]
                    step_r <= link.pllStrap ? PLL_RST : LINK_OFF; // [R9]
                PLL_RST: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_PLL_RESET;
                    link.wrData <= 16'h0001; // [R6]
                    step_r <= BIAS;
                end
                BIAS: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_OSC_BIAS;
                    link.wrData <= {8'h00, OSCILLATOR_BIAS_VAL}; // [R6]
                    step_r <= DIV;
                end
                DIV: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_PLL_DIV;
                    link.wrData <= pllCfg_r[15:0]; // [R6]
                    step_r <= TRIM;
                end
                TRIM: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_TRIM_CAL;
                    link.wrData <= {15'h0000, ctrl_r[C_TRIM_AUTO]}; // [R7]
                    step_r <= ctrl_r[C_TRIM_AUTO] ? PLL_REL : TRIM_VAL;
                end
                TRIM_VAL: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_TRIM_VAL;
                    link.wrData <= pllCfg_r[31:16]; // [R7]
                    step_r <= PLL_REL;
                end
                PLL_REL: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_PLL_RESET;
                    link.wrData <= 16'h0000; // [R8]
                    step_r <= LINK_OFF;
                end
                LINK_OFF: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_LINK_EN;
                    link.wrData <= 16'h0000; // [R10]
                    step_r <= CAL_OFF;
                end
                CAL_OFF: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_CAL_EN;
                    link.wrData <= 16'h0000; // [R11]
                    step_r <= MODE;
                end
                MODE: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_MODE;
                    link.wrData <= 16'(linkCfg_r[MODE_W-1:0]);
                    step_r <= KM1;
                end
                KM1: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_KM1;
                    link.wrData <= 16'(linkCfg_r[MODE_W +: K_W]); // [R12]
                    step_r <= SYNC;
                end
                SYNC: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_SYNC_SEL;
                    link.wrData <= {15'h0000, linkCfg_r[L_SYNCSEL]};
                    step_r <= CALCFG;
                end
                CALCFG: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_CAL_CFG;
                    link.wrData <= calCfg_r[15:0]; // [R14]
                    step_r <= AUX;
                end
                AUX: begin
                    link.wrEn <= ctrl_r[C_AUX_EN]; // [R15]
                    link.regAddr <= DR_AUX_CTRL;
                    link.wrData <= calCfg_r[31:16];
                    timer_r <= '0;
                    step_r <= link.pllStrap ? POLL_LOCK : CAL_ON;
                end
                POLL_LOCK: if (st[DST_TRIM] && st[DST_LOCK] && timer_r > 32'h2)
                    step_r <= CAL_ON; // [R16]
                CAL_ON: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_CAL_EN;
                    link.wrData <= 16'h0001; // [R17]
                    step_r <= OVR;
                end
                OVR: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_OVR;
                    link.wrData <= {15'h0000, ctrl_r[C_OVERRANGE_ENABLE]}; // [R17]
                    step_r <= LINK_ON;
                end
                LINK_ON: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_LINK_EN;
                    link.wrData <= 16'h0001; // [R17]
                    step_r <= TRIG0;
                end
                TRIG0: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_CAL_TRIG;
                    link.wrData <= {14'h0000, ctrl_r[C_PINTRIG], 1'b0}; // [R18]
                    step_r <= ctrl_r[C_PINTRIG] ? PIN_LO : TRIG1;
                end
                TRIG1: begin
                    link.wrEn <= 1'b1;
                    link.regAddr <= DR_CAL_TRIG;
                    link.wrData <= 16'h0001; // [R18]
                    timer_r <= '0;
                    step_r <= POLL_CAL;
                end
                PIN_LO: begin
                    link.calTriggerPin <= 1'b0; // [R19]
                    if (timer_r[3]) step_r <= PIN_HI;
                end
                PIN_HI: begin
                    link.calTriggerPin <= 1'b1; // [R19]
                    timer_r <= '0;
                    step_r <= POLL_CAL;
                end
                // status pin from an earlier run needs this long to drop through sync
                POLL_CAL: if (timer_r > 32'h8 && (calCfg_r[0] ? st[DST_FG] : cs2_r)) begin
                    step_r <= DONE; // [R20]
                end
                DONE: begin
                    // sync matters only in 8b/10b, linkUp covers both [R21] [R22]
                    valid_r <= lu2_r && !startReq;
                    if (startReq) step_r <= RST;
                end
                ERR: if (startReq) step_r <= RST;
            endcase
        end
    end
endmodule : bringup_host

// ### tb/bringup_asserts.sv
`timescale 1ns/1ps
module bringup_asserts (
    input logic clk,
    input logic sys_rst,
    input logic pllStrap,
    input logic wrEn,
    input bringup_pkg::dev_reg_t regAddr,
    input logic [15:0] wrData,
    input logic [15:0] rdData,
    input logic calTriggerPin,
    input logic calStatusPin,
    input logic linkUp
);
    import bringup_pkg::*;
    localparam int INIT_LO = INIT_CYC - 8;
    localparam int LOCK_LO = LOCK_CYC - 4;
    localparam int CAL_LO = CAL_CYC - 4;
    logic [15:0] initCnt_r, pllCnt_r, trigCnt_r;
    logic statRd_r, pinPrev_r, initSeen_r, lockSeen_r, pllHeld_r, linkOn_r, calOn_r, lastTrig_r;
    wire softWr = wrEn && regAddr == DR_SOFT_RESET && wrData[0];
    wire pllWr = wrEn && regAddr == DR_PLL_RESET;
    // a pin edge restarts the count too; the host only toggles the pin in pin-trigger mode
    wire trigEv = (wrEn && regAddr == DR_CAL_TRIG && wrData[0] && !lastTrig_r)
        || (calTriggerPin && !pinPrev_r);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // counters saturate so a long idle stretch never wraps into a false early flag
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            initCnt_r <= '1;
            pllCnt_r <= '0;
            trigCnt_r <= '0;
            statRd_r <= 1'b0;
            pinPrev_r <= 1'b0;
        end else begin
            initCnt_r <= softWr ? '0 : initCnt_r + {15'h0, initCnt_r != '1};
            pllCnt_r <= pllWr ? '0 : pllCnt_r + {15'h0, pllCnt_r != '1};
            trigCnt_r <= trigEv ? '0 : trigCnt_r + {15'h0, trigCnt_r != '1};
            statRd_r <= regAddr == DR_STATUS;
            pinPrev_r <= calTriggerPin;
        end
    end
    // enables start as on, so the host must switch them off before touching settings
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            initSeen_r <= 1'b0;
            lockSeen_r <= 1'b0;
            pllHeld_r <= 1'b0;
            linkOn_r <= 1'b1;
            calOn_r <= 1'b1;
            lastTrig_r <= 1'b1;
        end else begin
            initSeen_r <= !softWr && (initSeen_r || (statRd_r && rdData[DST_INIT] && initCnt_r > 3));
            lockSeen_r <= !pllWr && (lockSeen_r || (statRd_r && rdData[DST_LOCK] && pllCnt_r > 3));
            if (pllWr) pllHeld_r <= wrData[0];
            if (wrEn && regAddr == DR_LINK_EN) linkOn_r <= wrData[0];
            if (wrEn && regAddr == DR_CAL_EN) calOn_r <= wrData[0];
            if (wrEn && regAddr == DR_CAL_TRIG) lastTrig_r <= wrData[0];
        end
    end
    init_wait_a: assert property (wrEn && regAddr != DR_SOFT_RESET |-> initSeen_r)
        else $error("device write before init done");
    init_time_a: assert property (statRd_r && initCnt_r > 3 && initCnt_r < INIT_LO
        |-> !rdData[DST_INIT]) else $error("init flag too early");
    pll_skip_a: assert property (wrEn && !pllStrap |-> !(regAddr inside {DR_PLL_RESET,
        DR_OSC_BIAS, DR_PLL_DIV, DR_TRIM_CAL, DR_TRIM_VAL})) else $error("pll write in bypass");
    bias_value_a: assert property (wrEn && regAddr inside {DR_OSC_BIAS, DR_PLL_DIV}
        |-> pllHeld_r && (regAddr != DR_OSC_BIAS || wrData[7:0] == OSCILLATOR_BIAS_VAL))
        else $error("bad pll setup");
    lock_early_a: assert property (pllStrap && statRd_r && pllCnt_r > 3 && pllCnt_r < LOCK_LO
        |-> !rdData[DST_LOCK]) else $error("lock flag too early");
    lock_wait_a: assert property (wrEn && regAddr == DR_CAL_EN && wrData[0] && pllStrap
        |-> lockSeen_r) else $error("cal enabled before lock");
    link_hold_a: assert property (wrEn && regAddr inside {DR_MODE, DR_KM1, DR_SYNC_SEL}
        |-> !linkOn_r) else $error("link setting changed while running");
    cal_hold_a: assert property (wrEn && regAddr == DR_CAL_CFG |-> !calOn_r)
        else $error("cal setting changed while running");
    link_order_a: assert property (wrEn && regAddr == DR_LINK_EN && wrData[0] |-> calOn_r)
        else $error("link restarted before cal enable");
    link_stop_a: assert property (wrEn && regAddr == DR_LINK_EN && !wrData[0]
        |-> ##[1:4] !linkUp) else $error("link did not stop");
    trig_edge_a: assert property (wrEn && regAddr == DR_CAL_TRIG && wrData[0] |-> !lastTrig_r)
        else $error("trigger set without clear");
    cal_time_a: assert property ($rose(calStatusPin) |-> trigCnt_r >= CAL_LO)
        else $error("cal status early");
endmodule : bringup_asserts

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import bringup_pkg::*;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, linkRun, calRun;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rdv;
    logic [64:0] expQ[$];
    logic [64:0] e;
    int errCount = 0;
    int checked = 0;
    int seed = 32'h16e4;
    bringup_if bringup_if_inst();
    bringup_host bringup_host_inst(.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(bringup_if_inst.host));
    converter_device converter_device_inst(.clk(clk), .sys_rst(sys_rst),
        .link(bringup_if_inst.device), .linkRunning(linkRun), .calRunning(calRun));
    bringup_asserts bringup_asserts_inst(.clk(clk), .sys_rst(sys_rst),
        .pllStrap(bringup_if_inst.pllStrap), .wrEn(bringup_if_inst.wrEn),
        .regAddr(bringup_if_inst.regAddr), .wrData(bringup_if_inst.wrData),
        .rdData(bringup_if_inst.rdData), .calTriggerPin(bringup_if_inst.calTriggerPin),
        .calStatusPin(bringup_if_inst.calStatusPin), .linkUp(bringup_if_inst.linkUp));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errCount++;
            $display("FAIL %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task finish_test;
        if (errCount == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    // one idle cycle after each transfer keeps psel from being assigned twice in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic er);
        expQ.push_back({er, m, x});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task run(input logic pll, input logic pin, input logic hi);
        int n;
        logic [31:0] c;
        logic [3:0] mode;
        c = $random(seed);
        mode = {hi, c[22:20]};
        apb(1'b1, A_PLLCFG, c);
        rd(A_PLLCFG, 32'hffffffff, c, 1'b0);
        apb(1'b1, A_LINKCFG, {17'h0, c[14:4], mode});
        apb(1'b1, A_CALCFG, {16'h0081, 15'h0, c[0]});
        apb(1'b1, A_STATUS, 32'hffffffff);
        apb(1'b1, A_CTRL, {24'h0, pin, 2'b11, c[31], 2'b00, pll, 1'b1});
        n = 0;
        do begin
            rd(A_STATUS, 32'h4, 32'h0, 1'b0);
            n++;
        end while (rdv[S_DONE] !== 1'b1 && n < 3000);
        check({31'h0, rdv[S_DONE]}, 32'h1);
        // the sequencer parks in its done step, which still counts as busy
        rd(A_STATUS, hi ? 32'h1f : 32'h17, {27'h0, 1'b1, hi, 3'b011}, 1'b0);
        check({30'h0, linkRun, calRun}, 32'h3);
    endtask : run
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = expQ.pop_front();
            check(prdata & e[63:32], e[31:0]);
            check({31'h0, pslverr}, {31'h0, e[64]});
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(8'hfc, 32'hffffffff, 32'h0, 1'b1);
        run(1'b1, 1'b0, 1'b1);
        run(1'b0, 1'b1, 1'b0);
        finish_test;
    end
    // two runs need a few thousand cycles; ten times that means a hang
    initial begin
        #300000;
        errCount++;
        finish_test;
    end
endmodule : tb
